// [test/qpc_encoder_model.sv]
`timescale 1ns/1ps
module qpc_encoder_model (
  output logic phase_a, // Phase A pin
  output logic phase_b  // Phase B pin
);
  initial begin
    phase_a = 1'h0;
    phase_b = 1'h0;
  end

  // One detent: B gives the sense, then one 320 ns period on A
  task automatic turn(input logic up);
    #10 phase_b = up;
    #80 phase_a = 1'h1;
    #160 phase_a = 1'h0;
    #70;
  endtask : turn
endmodule : qpc_encoder_model

// [test/qpc_top_properties.sv]
`timescale 1ns/1ps
module qpc_top_properties
  import qpc_pkg::*;
(
  input wire logic        aclk,          // System clock
  input wire logic        aresetn,       // Reset, active low
  input wire logic [31:0] s_axi_awaddr,  // Write address
  input wire logic        s_axi_awvalid, // Write address valid
  input wire logic        s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata,   // Write data
  input wire logic        s_axi_wvalid,  // Write data valid
  input wire logic        s_axi_wready,  // Write data ready
  input wire logic        s_axi_bvalid,  // Write response valid
  input wire logic        s_axi_bready,  // Write response ready
  input wire logic [31:0] s_axi_araddr,  // Read address
  input wire logic        s_axi_arvalid, // Read address valid
  input wire logic        s_axi_arready, // Read address ready
  input wire logic [31:0] s_axi_rdata,   // Read data
  input wire logic        s_axi_rvalid,  // Read data valid
  input wire logic        s_axi_rready,  // Read data ready
  input wire logic        irq            // Interrupt request
);
  logic [31:0] ra_q;
  logic [31:0] wa_q;
  logic [15:0] wd_q;
  logic [15:0] ctl_q;

  always_ff @(posedge aclk) begin
    if (s_axi_arvalid && s_axi_arready) ra_q <= s_axi_araddr;
  end

  always_ff @(posedge aclk) begin
    if (s_axi_awvalid && s_axi_awready) wa_q <= s_axi_awaddr;
    if (s_axi_wvalid && s_axi_wready) wd_q <= s_axi_wdata[15:0];
  end

  // Shadow of the control word, taken at the write response
  always_ff @(posedge aclk) begin
    if (!aresetn) ctl_q <= 16'h0000;
    else if (s_axi_bvalid && s_axi_bready && wa_q == ADDR_CONTROL) ctl_q <= wd_q;
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_RST_IDLE:
    assert property ($rose(aresetn) |-> s_axi_awready && s_axi_arready && !s_axi_bvalid
      && !s_axi_rvalid && !irq) else $error("not idle after reset");
  AST_B_AFTER:
    assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##2 s_axi_bvalid) else $error("write response late");
  AST_R_AFTER:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read late");
  AST_R_ONCE:
    assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("read twice");
  AST_STA_RSVD:
    assert property (s_axi_rvalid && ra_q == ADDR_STATUS
      |-> s_axi_rdata[31:5] == 27'h0 && !s_axi_rdata[3]) else $error("status spare bits set");
  AST_LIMIT_W:
    assert property (s_axi_rvalid && ra_q == ADDR_LIMIT |-> s_axi_rdata[31:16] == 16'h0)
      else $error("limit too wide");
  AST_COUNT_W:
    assert property (s_axi_rvalid && ra_q == ADDR_COUNT |-> s_axi_rdata[31:16] == 16'h0)
      else $error("count too wide");
  AST_TRIG_RD:
    assert property (s_axi_rvalid && (ra_q == ADDR_CLEAR || ra_q == ADDR_PRELOAD)
      |-> s_axi_rdata == 32'h0) else $error("trigger register read not zero");
  AST_IRQ_CAUSE:
    assert property ($rose(irq) |-> ctl_q[CTL_EDGE_IE] || ctl_q[CTL_WRAP_LO_IE]
      || ctl_q[CTL_WRAP_HI_IE]) else $error("irq with no source enabled");
endmodule : qpc_top_properties

bind qpc_top qpc_top_properties u_props (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .irq(irq));

// [test/qpc_top_tb.sv]
`timescale 1ns/1ps
module qpc_top_tb
  import qpc_pkg::*;
;
  logic        aclk = 1'h0;
  logic        aresetn = 1'h0;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata;
  logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic        awready, wready, bvalid, arready, rvalid, irq, pa, pb;
  logic [1:0]  bresp, rresp;
  logic [1:0]  fn_a = 2'h1;
  logic [1:0]  fn_b = 2'h1;
  logic [3:0]  wstrb = 4'hF;
  int          err_count = 0;
  int          n_compared = 0;
  int          cyc = 0;

  always #20 aclk = ~aclk;

  qpc_encoder_model enc (.phase_a(pa), .phase_b(pb));
  qpc_top dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .phase_a_input(pa), .phase_b_input(pb), .phase_a_pin_function(fn_a),
    .phase_b_pin_function(fn_b), .irq(irq));

  task automatic wrap_up();
    $display("compared %0d, errors %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_count++;
      wrap_up();
    end
  end

  task automatic check(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("ERROR at %0t: got %h expected %h", $time, g, e);
    end
  endtask : check

  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] e = 2'h0);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while (!bvalid);
    bready <= 1'h0;
    check({30'h0, bresp}, {30'h0, e});
  endtask : wr

  task automatic rd(input logic [31:0] a, input logic [31:0] e, input logic [1:0] er = 2'h0);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'h0;
    end while (!rvalid);
    rready <= 1'h0;
    check(rdata, e);
    check({30'h0, rresp}, {30'h0, er});
  endtask : rd

  task automatic sense_irq(input logic e);
    @(negedge aclk);
    check({31'h0, irq}, {31'h0, e});
  endtask : sense_irq

  task automatic t_reset();
    rd(ADDR_LIMIT, 32'h0000FFFF);
    rd(ADDR_COUNT, 32'h0);
    rd(ADDR_STATUS, 32'h0);
    rd(32'hFFFF0F10, 32'h0, RESP_DECERR);
    wr(32'hFFFF0F1C, 32'h1, RESP_DECERR);
    sense_irq(1'h0);
  endtask : t_reset

  task automatic t_up_wrap();
    wr(ADDR_LIMIT, 32'h3);
    rd(ADDR_LIMIT, 32'h3);
    wr(ADDR_CONTROL, 32'h2D);
    repeat (3) enc.turn(1'h1);
    rd(ADDR_COUNT, 32'h3);
    sense_irq(1'h1);
    rd(ADDR_STATUS, 32'h11);
    rd(ADDR_STATUS, 32'h01);
    sense_irq(1'h0);
    enc.turn(1'h1);
    rd(ADDR_COUNT, 32'h0);
    rd(ADDR_STATUS, 32'h13);
    enc.turn(1'h1);
    rd(ADDR_COUNT, 32'h1);
  endtask : t_up_wrap

  task automatic t_down_wrap();
    wr(ADDR_CLEAR, 32'hA5A5A5A5);
    rd(ADDR_COUNT, 32'h0);
    rd(ADDR_STATUS, 32'h11);
    enc.turn(1'h0);
    rd(ADDR_COUNT, 32'h3);
    rd(ADDR_STATUS, 32'h14);
  endtask : t_down_wrap

  task automatic t_load();
    wr(ADDR_LIMIT, 32'h5);
    wr(ADDR_PRELOAD, 32'h0);
    rd(ADDR_COUNT, 32'h5);
    wstrb <= 4'h1;
    wr(ADDR_COUNT, 32'h0000FF02);
    wstrb <= 4'hF;
    rd(ADDR_COUNT, 32'h2);
    rd(ADDR_CLEAR, 32'h0);
    rd(ADDR_PRELOAD, 32'h0);
  endtask : t_load

  task automatic t_mask();
    wr(ADDR_CONTROL, 32'h1);
    repeat (4) enc.turn(1'h1);
    rd(ADDR_COUNT, 32'h0);
    sense_irq(1'h0);
    rd(ADDR_STATUS, 32'h13);
  endtask : t_mask

  task automatic t_off();
    wr(ADDR_CONTROL, 32'h0);
    enc.turn(1'h0);
    rd(ADDR_COUNT, 32'h0);
    rd(ADDR_STATUS, 32'h01);
    wr(ADDR_CONTROL, 32'h1);
    fn_a <= 2'h2;
    enc.turn(1'h1);
    rd(ADDR_COUNT, 32'h0);
    fn_a <= 2'h1;
    fn_b <= 2'h2;
    enc.turn(1'h1);
    rd(ADDR_COUNT, 32'h5);
    fn_b <= 2'h1;
    wr(ADDR_CLEAR, 32'h0);
  endtask : t_off

  task automatic t_fixed();
    wr(ADDR_CONTROL, 32'h141);
    enc.turn(1'h0);
    rd(ADDR_COUNT, 32'h1);
    wr(ADDR_CONTROL, 32'h41);
    enc.turn(1'h1);
    rd(ADDR_COUNT, 32'h0);
  endtask : t_fixed

  task automatic t_filter();
    wr(ADDR_CONTROL, 32'h401);
    rd(ADDR_STATUS, 32'h14);
    enc.turn(1'h1);
    rd(ADDR_COUNT, 32'h0);
    rd(ADDR_STATUS, 32'h10);
    enc.turn(1'h0);
    rd(ADDR_COUNT, 32'h5);
  endtask : t_filter

  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    t_reset();
    t_up_wrap();
    t_down_wrap();
    t_load();
    t_mask();
    t_off();
    t_fixed();
    t_filter();
    wrap_up();
  end
endmodule : qpc_top_tb

// [verilog/qpc_pkg.sv]
package qpc_pkg;

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [31:0] ADDR_CONTROL  = 32'hFFFF0F00;
  localparam logic [31:0] ADDR_STATUS   = 32'hFFFF0F04;
  localparam logic [31:0] ADDR_LIMIT    = 32'hFFFF0F08;
  localparam logic [31:0] ADDR_COUNT    = 32'hFFFF0F0C;
  localparam logic [31:0] ADDR_CLEAR    = 32'hFFFF0F14;
  localparam logic [31:0] ADDR_PRELOAD  = 32'hFFFF0F18;

  // ----------------------------------------------------------------
  // Control fields
  // ----------------------------------------------------------------
  localparam int CTL_ENABLE      = 0;
  localparam int CTL_WRAP_HI_IE  = 2;
  localparam int CTL_WRAP_LO_IE  = 3;
  localparam int CTL_EDGE_IE     = 5;
  localparam int CTL_FIXED_SENSE = 6;
  localparam int CTL_A_INVERT    = 7;
  localparam int CTL_B_INVERT    = 8;
  localparam int CTL_FILTER      = 10;
  localparam logic [15:0] CTL_WMASK = 16'h05ED;

  // ----------------------------------------------------------------
  // Status fields
  // ----------------------------------------------------------------
  localparam int STA_SENSE   = 0;
  localparam int STA_WRAP_HI = 1;
  localparam int STA_WRAP_LO = 2;
  localparam int STA_EDGE    = 4;

  // ----------------------------------------------------------------
  // Reset values and encodings
  // ----------------------------------------------------------------
  localparam logic [15:0] CONTROL_RST = 16'h0000;
  localparam logic [15:0] LIMIT_RST   = 16'hFFFF;
  localparam logic [15:0] COUNT_RST   = 16'h0000;
  localparam logic [2:0]  FLAGS_RST   = 3'h0;
  localparam logic [1:0]  PIN_FN_ENC  = 2'h1;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_DECERR = 2'h3;

  // ----------------------------------------------------------------
  // Gray conversion
  // ----------------------------------------------------------------
  function automatic logic [15:0] qpc_bin2gray(input logic [15:0] b);
    qpc_bin2gray = b ^ (b >> 1);
  endfunction : qpc_bin2gray

  function automatic logic [15:0] qpc_gray2bin(input logic [15:0] g);
    logic [15:0] b;
    b[15] = g[15];
    for (int i = 14; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    qpc_gray2bin = b;
  endfunction : qpc_gray2bin

endpackage : qpc_pkg

// [verilog/qpc_sync.sv]
`timescale 1ns/1ps
module qpc_sync #(
  parameter int W = 2
) (
  input  wire logic         aclk,    // System clock
  input  wire logic         aresetn, // Synchronous reset, active low
  input  wire logic [W-1:0] d,       // Asynchronous levels
  output logic      [W-1:0] q        // Synchronised levels
);

  logic [W-1:0] meta_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule : qpc_sync

// [verilog/qpc_top.sv]
`timescale 1ns/1ps
module qpc_top
  import qpc_pkg::*;
(
  input  wire logic        aclk,                 // System clock
  input  wire logic        aresetn,              // Synchronous reset, active low
  input  wire logic [31:0] s_axi_awaddr,         // Write address
  input  wire logic [2:0]  s_axi_awprot,         // Write protection, unused
  input  wire logic        s_axi_awvalid,        // Write address valid
  output logic             s_axi_awready,        // Write address ready
  input  wire logic [31:0] s_axi_wdata,          // Write data
  input  wire logic [3:0]  s_axi_wstrb,          // Write byte strobes
  input  wire logic        s_axi_wvalid,         // Write data valid
  output logic             s_axi_wready,         // Write data ready
  output logic [1:0]       s_axi_bresp,          // Write response
  output logic             s_axi_bvalid,         // Write response valid
  input  wire logic        s_axi_bready,         // Write response ready
  input  wire logic [31:0] s_axi_araddr,         // Read address
  input  wire logic [2:0]  s_axi_arprot,         // Read protection, unused
  input  wire logic        s_axi_arvalid,        // Read address valid
  output logic             s_axi_arready,        // Read address ready
  output logic [31:0]      s_axi_rdata,          // Read data
  output logic [1:0]       s_axi_rresp,          // Read response
  output logic             s_axi_rvalid,         // Read data valid
  input  wire logic        s_axi_rready,         // Read data ready
  input  wire logic        phase_a_input,        // Encoder phase A pin
  input  wire logic        phase_b_input,        // Encoder phase B pin
  input  wire logic [1:0]  phase_a_pin_function, // Pin mux select, phase A pin
  input  wire logic [1:0]  phase_b_pin_function, // Pin mux select, phase B pin
  output logic             irq                   // Interrupt request
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [15:0] control_q;
  logic [15:0] limit_q;
  logic [15:0] gray_q;
  logic        mirror_q;
  logic [15:0] count_rd_q;
  logic        sense_q;
  logic [2:0]  flags_q;
  logic        irq_q;
  logic [1:0]  phase_sync;
  logic        a_prev_q;
  logic        b_prev_q;
  logic        b_moved_q;
  logic [31:0] aw_addr_q;
  logic        aw_full_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;
  logic        w_full_q;
  logic        awready_q;
  logic        wready_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  logic        arready_q;
  logic        rvalid_q;
  logic [1:0]  rresp_q;
  logic [31:0] rdata_q;

  logic        a_lvl;
  logic        b_lvl;
  logic        a_rise;
  logic        b_edge;
  logic        enabled;
  logic        count_up;
  logic        step;
  logic [15:0] raw_bin;
  logic [15:0] cur_count;
  logic        at_top;
  logic        at_bottom;
  logic        wrap_hi;
  logic        wrap_lo;
  logic        do_wr;
  logic        ar_hs;
  logic        wr_control;
  logic        wr_limit;
  logic        wr_count;
  logic        wr_clear;
  logic        wr_preload;
  logic        rd_status;
  logic [2:0]  flag_set;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] data,
                                          input logic [3:0]  strb);
    logic [15:0] r;
    r = old;
    if (strb[0]) r[7:0] = data[7:0];
    if (strb[1]) r[15:8] = data[15:8];
    merge16 = r;
  endfunction : merge16

  function automatic logic is_mapped(input logic [31:0] a);
    is_mapped = (a == ADDR_CONTROL) || (a == ADDR_STATUS) ||
                (a == ADDR_LIMIT)   || (a == ADDR_COUNT)  ||
                (a == ADDR_CLEAR)   || (a == ADDR_PRELOAD);
  endfunction : is_mapped

  // ----------------------------------------------------------------
  // Phase input capture
  // ----------------------------------------------------------------
  qpc_sync #(
    .W (2)
  ) u_phase_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       ({phase_b_input, phase_a_input}),
    .q       (phase_sync)
  );

  // Pins not muxed to the encoder read as idle low
  assign a_lvl = (phase_a_pin_function == PIN_FN_ENC) &&
                 (phase_sync[0] ^ control_q[CTL_A_INVERT]);
  assign b_lvl = (phase_b_pin_function == PIN_FN_ENC) &&
                 (phase_sync[1] ^ control_q[CTL_B_INVERT]);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      a_prev_q <= 1'b0;
      b_prev_q <= 1'b0;
    end else begin
      a_prev_q <= a_lvl;
      b_prev_q <= b_lvl;
    end
  end

  assign a_rise  = a_lvl && !a_prev_q;
  assign b_edge  = b_lvl != b_prev_q;
  assign enabled = control_q[CTL_ENABLE];

  // Filter: an A edge counts only after B has moved since the last one
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      b_moved_q <= 1'b0;
    end else if (step) begin
      b_moved_q <= b_edge;
    end else if (b_edge) begin
      b_moved_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Count sense and stepping
  // ----------------------------------------------------------------
  assign count_up = control_q[CTL_FIXED_SENSE] ? control_q[CTL_B_INVERT]
                                               : b_lvl;
  assign step     = enabled && a_rise &&
                    (!control_q[CTL_FILTER] || b_moved_q);

  // ----------------------------------------------------------------
  // Gray counter with mirrored read-back
  // ----------------------------------------------------------------
  assign raw_bin   = qpc_gray2bin(gray_q);
  assign cur_count = mirror_q ? (limit_q - raw_bin) : raw_bin;
  assign at_top    = cur_count >= limit_q;
  assign at_bottom = cur_count == COUNT_RST;
  assign wrap_hi   = step && count_up && at_top;
  assign wrap_lo   = step && !count_up && at_bottom;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gray_q   <= qpc_bin2gray(COUNT_RST);
      mirror_q <= 1'b0;
    end else if (wr_clear) begin
      gray_q   <= qpc_bin2gray(COUNT_RST);
      mirror_q <= 1'b0;
    end else if (wr_preload) begin
      gray_q   <= qpc_bin2gray(limit_q);
      mirror_q <= 1'b0;
    end else if (wr_count) begin
      gray_q   <= qpc_bin2gray(merge16(cur_count, w_data_q, w_strb_q));
      mirror_q <= 1'b0;
    end else if (wrap_hi || wrap_lo) begin
      // Gray value holds; the mirror turns the read-back round
      mirror_q <= !mirror_q;
    end else if (step) begin
      if (count_up ^ mirror_q) begin
        gray_q <= qpc_bin2gray(raw_bin + 16'h0001);
      end else begin
        gray_q <= qpc_bin2gray(raw_bin - 16'h0001);
      end
    end
  end

  // Read-back copy of the count
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_rd_q <= COUNT_RST;
    end else begin
      count_rd_q <= cur_count;
    end
  end

  // ----------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------
  assign flag_set = {enabled && a_rise, wrap_lo, wrap_hi};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags_q <= FLAGS_RST;
    end else if (rd_status) begin
      flags_q <= flag_set;
    end else begin
      flags_q <= flags_q | flag_set;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sense_q <= 1'b0;
    end else if (step) begin
      sense_q <= count_up;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= (flags_q[2] && control_q[CTL_EDGE_IE])    ||
               (flags_q[1] && control_q[CTL_WRAP_LO_IE]) ||
               (flags_q[0] && control_q[CTL_WRAP_HI_IE]);
    end
  end

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  assign do_wr      = aw_full_q && w_full_q && !bvalid_q;
  assign wr_control = do_wr && (aw_addr_q == ADDR_CONTROL);
  assign wr_limit   = do_wr && (aw_addr_q == ADDR_LIMIT);
  assign wr_count   = do_wr && (aw_addr_q == ADDR_COUNT);
  assign wr_clear   = do_wr && (aw_addr_q == ADDR_CLEAR);
  assign wr_preload = do_wr && (aw_addr_q == ADDR_PRELOAD);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      control_q <= CONTROL_RST;
    end else if (wr_control) begin
      control_q <= merge16(control_q, w_data_q, w_strb_q) & CTL_WMASK;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      limit_q <= LIMIT_RST;
    end else if (wr_limit) begin
      limit_q <= merge16(limit_q, w_data_q, w_strb_q);
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite write channels
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b1;
      aw_full_q <= 1'b0;
      aw_addr_q <= 32'h00000000;
    end else if (s_axi_awvalid && awready_q) begin
      awready_q <= 1'b0;
      aw_full_q <= 1'b1;
      aw_addr_q <= s_axi_awaddr;
    end else if (do_wr) begin
      aw_full_q <= 1'b0;
    end else if (bvalid_q && s_axi_bready) begin
      awready_q <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready_q <= 1'b1;
      w_full_q <= 1'b0;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
    end else if (s_axi_wvalid && wready_q) begin
      wready_q <= 1'b0;
      w_full_q <= 1'b1;
      w_data_q <= s_axi_wdata;
      w_strb_q <= s_axi_wstrb;
    end else if (do_wr) begin
      w_full_q <= 1'b0;
    end else if (bvalid_q && s_axi_bready) begin
      wready_q <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
    end else if (do_wr) begin
      bvalid_q <= 1'b1;
      bresp_q  <= is_mapped(aw_addr_q) ? RESP_OKAY : RESP_DECERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read channels
  // ----------------------------------------------------------------
  assign ar_hs     = s_axi_arvalid && arready_q;
  assign rd_status = ar_hs && (s_axi_araddr == ADDR_STATUS);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
    end else if (ar_hs) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b1;
    end else if (rvalid_q && s_axi_rready) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rdata_q <= 32'h00000000;
      rresp_q <= RESP_OKAY;
    end else if (ar_hs) begin
      rresp_q <= RESP_OKAY;
      rdata_q <= 32'h00000000;
      unique case (s_axi_araddr)
        ADDR_CONTROL: rdata_q[15:0] <= control_q;
        ADDR_STATUS: begin
          // Reserved status bits stay zero
          rdata_q[STA_EDGE]    <= flags_q[2];
          rdata_q[STA_WRAP_LO] <= flags_q[1];
          rdata_q[STA_WRAP_HI] <= flags_q[0];
          rdata_q[STA_SENSE]   <= sense_q;
        end
        ADDR_LIMIT: rdata_q[15:0] <= limit_q;
        ADDR_COUNT: rdata_q[15:0] <= count_rd_q;
        ADDR_CLEAR, ADDR_PRELOAD: rdata_q <= 32'h00000000;
        default: rresp_q <= RESP_DECERR;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign s_axi_awready = awready_q;
  assign s_axi_wready  = wready_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rresp   = rresp_q;
  assign s_axi_rdata   = rdata_q;
  assign irq           = irq_q;

endmodule : qpc_top
